// *** hdl/rtc_cal_regs.svh ***
// Register offsets, reset values, field positions and limits of the calendar block
`ifndef RTC_CAL_REGS_SVH
`define RTC_CAL_REGS_SVH
`define OFS_HOUR_ALARM  8'h05
`define OFS_WEEKDAY     8'h06
`define OFS_DATE        8'h07
`define OFS_MONTH       8'h08
`define OFS_YEAR        8'h09
`define OFS_CONFIG      8'h30
`define OFS_IRQ_STATUS  8'h31
`define OFS_IRQ_MASK    8'h32
`define RST_COUNTER     8'h00
`define RST_CONFIG      2'h0
`define RST_IRQ         2'h0
`define CFG_BINARY_POS  2
`define CFG_HOUR24_POS  1
`define IRQ_ALARM_POS   0
`define IRQ_DAY_POS     1
`define WILDCARD_TOP    2'h3
`define AFTERNOON_POS   7
`define WEEKDAY_FIRST   8'h01
`define WEEKDAY_LAST    8'h07
`define DATE_FIRST      7'h01
`define MONTH_FIRST     7'h01
`define MONTH_LAST      7'h0c
`define YEAR_FIRST      7'h00
`define YEAR_LAST       7'h63
`endif

// *** hdl/rtc_cal_pkg.sv ***
// Types shared by the calendar block modules
package rtc_cal_pkg;
   typedef logic [7:0] byte_type;
   typedef struct packed {
      byte_type   hourAlarm;
      byte_type   weekday;
      byte_type   date;
      byte_type   month;
      byte_type   year;
      logic [1:0] cfgBits;
      logic [1:0] status;
      logic [1:0] mask;
      byte_type   rdData;
      logic       alarmEvent;
   } cal_state_type;
endpackage

// *** hdl/cal_step_if.sv ***
// Interface carrying the calendar values to the rollover stepper and back
`timescale 1ns/1ps
interface cal_step_if;
   import rtc_cal_pkg::*;
   byte_type weekday;
   byte_type date;
   byte_type month;
   byte_type year;
   logic     binMode;
   byte_type nextWeekday;
   byte_type nextDate;
   byte_type nextMonth;
   byte_type nextYear;
   modport holder (output weekday, date, month, year, binMode,
                   input nextWeekday, nextDate, nextMonth, nextYear);
   modport stepper (input weekday, date, month, year, binMode,
                    output nextWeekday, nextDate, nextMonth, nextYear);
endinterface

// *** hdl/rtc_date_step.sv ***
// Combinational day-rollover stepper for weekday, date, month and year
`timescale 1ns/1ps
`include "rtc_cal_regs.svh"
module rtc_date_step
   import rtc_cal_pkg::*;
(
   cal_step_if.stepper s
);
   function automatic logic [6:0] toBin(input logic [7:0] v, input logic bin);
      toBin = bin ? v[6:0] : 7'(7'(v[7:4]) * 7'd10 + 7'(v[3:0]));
   endfunction

   function automatic byte_type fromBin(input logic [6:0] v, input logic bin);
      fromBin = bin ? {1'b0, v} : {4'(v / 7'd10), 4'(v % 7'd10)};
   endfunction

   // Every year of 2000..2099 divisible by four is a leap year
   function automatic logic [6:0] monthDays(input logic [6:0] m, input logic [6:0] y);
      case (m)
         7'd2:    monthDays = (y[1:0] == 2'h0) ? 7'd29 : 7'd28;
         7'd4,
         7'd6,
         7'd9,
         7'd11:   monthDays = 7'd30;
         default: monthDays = 7'd31;
      endcase
   endfunction

   always_comb
   begin
      logic [6:0] d;
      logic [6:0] m;
      logic [6:0] y;
      d = toBin(s.date, s.binMode);
      m = toBin(s.month, s.binMode);
      y = toBin(s.year, s.binMode);
      // Weekday reads alike in both formats, so it is stepped raw
      if (s.weekday >= `WEEKDAY_LAST || s.weekday < `WEEKDAY_FIRST)
         s.nextWeekday = `WEEKDAY_FIRST;
      else
         s.nextWeekday = s.weekday + 8'h01;
      if (d >= monthDays(m, y))
      begin
         d = `DATE_FIRST;
         if (m >= `MONTH_LAST)
         begin
            m = `MONTH_FIRST;
            y = (y >= `YEAR_LAST) ? `YEAR_FIRST : y + 7'd1;
         end
         else
            m = m + 7'd1;
      end
      else
         d = d + 7'd1;
      s.nextDate  = fromBin(d, s.binMode);
      s.nextMonth = fromBin(m, s.binMode);
      s.nextYear  = fromBin(y, s.binMode);
   end
endmodule

// *** hdl/rtc_calendar.sv ***
// Hour alarm match and calendar counters with register port and interrupt
`timescale 1ns/1ps
`include "rtc_cal_regs.svh"
module rtc_calendar
   import rtc_cal_pkg::*;
(
   input  wire logic     ref_clk,
   input  wire logic     rstn,
   input  wire byte_type regAddr,
   input  wire byte_type regWrData,
   input  wire logic     regWr,
   input  wire logic     regRd,
   output byte_type      regRdData,
   input  wire logic     updateTick,
   input  wire logic     dayRollover,
   input  wire byte_type secondsCount,
   input  wire byte_type minutesCount,
   input  wire byte_type hoursCount,
   input  wire byte_type secondsAlarm,
   input  wire byte_type minutesAlarm,
   output logic          binaryFormatSelect,
   output logic          hour24Select,
   output logic          alarmEvent,
   output logic          irq
);
   // ----------------------------------------------------------------
   // Match helpers
   // ----------------------------------------------------------------
   function automatic logic fieldMatch(input byte_type alarmVal, input byte_type countVal);
      fieldMatch = (alarmVal[7:6] == `WILDCARD_TOP) || (alarmVal == countVal);
   endfunction

   function automatic logic isWildcard(input byte_type v);
      isWildcard = (v[7:6] == `WILDCARD_TOP);
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   cal_state_type q;
   cal_state_type d;
   cal_step_if    step ();
   logic          secMatch;
   logic          minMatch;
   logic          hourMatch;
   logic          alarmHit;
   byte_type      hoursSeen;
   logic [1:0]    statusClr;
   logic [1:0]    statusSet;

   rtc_date_step u_step
   (
      .s (step.stepper)
   );

   assign step.weekday = q.weekday;
   assign step.date    = q.date;
   assign step.month   = q.month;
   assign step.year    = q.year;
   assign step.binMode = q.cfgBits[`CFG_BINARY_POS - 1];

   assign binaryFormatSelect = q.cfgBits[`CFG_BINARY_POS - 1];
   assign hour24Select       = q.cfgBits[`CFG_HOUR24_POS - 1];
   assign regRdData          = q.rdData;
   assign alarmEvent         = q.alarmEvent;
   assign irq                = |(q.status & q.mask);

   // ----------------------------------------------------------------
   // Alarm comparison
   // ----------------------------------------------------------------
   // In 24-hour mode the afternoon flag of the hours count is ignored
   assign hoursSeen = hour24Select ? {1'b0, hoursCount[6:0]} : hoursCount;
   assign secMatch  = fieldMatch(secondsAlarm, secondsCount);
   assign minMatch  = fieldMatch(minutesAlarm, minutesCount);
   assign hourMatch = fieldMatch(q.hourAlarm, hoursSeen);
   assign alarmHit  = updateTick && secMatch && minMatch && hourMatch;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      d            = q;
      d.rdData     = 8'h00;
      d.alarmEvent = alarmHit;
      statusSet    = 2'h0;
      statusClr    = 2'h0;
      statusSet[`IRQ_ALARM_POS] = alarmHit;
      statusSet[`IRQ_DAY_POS]   = dayRollover;
      if (dayRollover)
      begin
         d.weekday = step.nextWeekday;
         d.date    = step.nextDate;
         d.month   = step.nextMonth;
         d.year    = step.nextYear;
      end
      // A software write lands after the rollover so the written value wins
      if (regWr)
      begin
         case (regAddr)
            `OFS_HOUR_ALARM:
            begin
               d.hourAlarm = regWrData;
               // 24-hour mode holds the afternoon flag low unless wildcarded
               if (hour24Select && !isWildcard(regWrData))
                  d.hourAlarm[`AFTERNOON_POS] = 1'b0;
            end
            `OFS_WEEKDAY:    d.weekday = regWrData;
            `OFS_DATE:       d.date    = regWrData;
            `OFS_MONTH:      d.month   = regWrData;
            `OFS_YEAR:       d.year    = regWrData;
            `OFS_CONFIG:
            begin
               d.cfgBits[`CFG_BINARY_POS - 1] = regWrData[`CFG_BINARY_POS];
               d.cfgBits[`CFG_HOUR24_POS - 1] = regWrData[`CFG_HOUR24_POS];
            end
            `OFS_IRQ_STATUS: statusClr = regWrData[1:0];
            `OFS_IRQ_MASK:   d.mask    = regWrData[1:0];
            default:         d.mask    = q.mask;
         endcase
      end
      // Set wins over a clear arriving in the same cycle
      d.status = (q.status & ~statusClr) | statusSet;
      if (regRd)
      begin
         case (regAddr)
            `OFS_HOUR_ALARM: d.rdData = q.hourAlarm;
            `OFS_WEEKDAY:    d.rdData = q.weekday;
            `OFS_DATE:       d.rdData = q.date;
            `OFS_MONTH:      d.rdData = q.month;
            `OFS_YEAR:       d.rdData = q.year;
            `OFS_CONFIG:
            begin
               d.rdData[`CFG_BINARY_POS] = q.cfgBits[`CFG_BINARY_POS - 1];
               d.rdData[`CFG_HOUR24_POS] = q.cfgBits[`CFG_HOUR24_POS - 1];
            end
            `OFS_IRQ_STATUS: d.rdData = {6'h00, q.status};
            `OFS_IRQ_MASK:   d.rdData = {6'h00, q.mask};
            default:         d.rdData = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         q.hourAlarm  <= `RST_COUNTER;
         q.weekday    <= `RST_COUNTER;
         q.date       <= `RST_COUNTER;
         q.month      <= `RST_COUNTER;
         q.year       <= `RST_COUNTER;
         q.cfgBits    <= `RST_CONFIG;
         q.status     <= `RST_IRQ;
         q.mask       <= `RST_IRQ;
         q.rdData     <= 8'h00;
         q.alarmEvent <= 1'b0;
      end
      else
         q <= d;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   property p_hourWildcard;
      updateTick && secMatch && minMatch && isWildcard(q.hourAlarm)
         |=> alarmEvent;
   endproperty
   a_hourWildcard: assert property (p_hourWildcard)
      else $error("wildcard hour alarm did not fire");

   property p_hourMismatch;
      updateTick && !isWildcard(q.hourAlarm) && (q.hourAlarm != hoursSeen)
         |=> !alarmEvent;
   endproperty
   a_hourMismatch: assert property (p_hourMismatch)
      else $error("alarm fired with hours not matching");

   property p_secMismatch;
      updateTick && !isWildcard(secondsAlarm) && (secondsAlarm != secondsCount)
         |=> !alarmEvent;
   endproperty
   a_secMismatch: assert property (p_secMismatch)
      else $error("alarm fired with seconds not matching");

   property p_alarmCause;
      alarmEvent |-> $past(updateTick) && $past(secMatch) && $past(minMatch) && $past(hourMatch);
   endproperty
   a_alarmCause: assert property (p_alarmCause)
      else $error("alarm event without a full match on an update");

   property p_weekdayWrap;
      dayRollover && !regWr && (q.weekday == `WEEKDAY_LAST)
         |=> (q.weekday == `WEEKDAY_FIRST) ##1 (q.weekday == `WEEKDAY_FIRST || $past(regWr)
             || $past(dayRollover));
   endproperty
   a_weekdayWrap: assert property (p_weekdayWrap)
      else $error("weekday did not wrap from 7 to 1");

   property p_yearWrap;
      dayRollover && !regWr && binaryFormatSelect && (q.month == 8'h0c)
         && (q.date == 8'h1f) && (q.year == 8'h63)
         |=> (q.year == 8'h00) && (q.month == 8'h01) && (q.date == 8'h01);
   endproperty
   a_yearWrap: assert property (p_yearWrap)
      else $error("year did not wrap from 99 to 0");

   property p_leapDay;
      dayRollover && !regWr && binaryFormatSelect && (q.month == 8'h02)
         && (q.date == 8'h1c) && (q.year == 8'h04)
         |=> (q.date == 8'h1d) && (q.month == 8'h02);
   endproperty
   a_leapDay: assert property (p_leapDay)
      else $error("leap year February ended on the 28th");

   property p_bcdDate;
      dayRollover && !regWr && !binaryFormatSelect && (q.date == 8'h09)
         |=> (q.date == 8'h10);
   endproperty
   a_bcdDate: assert property (p_bcdDate)
      else $error("BCD date did not carry into the tens digit");

   property p_monthWrap;
      dayRollover && !regWr && binaryFormatSelect && (q.month == 8'h0b)
         && (q.date == 8'h1e)
         |=> (q.month == 8'h0c) && (q.date == 8'h01);
   endproperty
   a_monthWrap: assert property (p_monthWrap)
      else $error("30-day month did not advance correctly");

   property p_noon24;
      regWr && (regAddr == `OFS_HOUR_ALARM) && hour24Select && !isWildcard(regWrData)
         |=> !q.hourAlarm[`AFTERNOON_POS];
   endproperty
   a_noon24: assert property (p_noon24)
      else $error("afternoon flag kept in 24-hour mode");

   property p_readLatency;
      regRd && (regAddr == `OFS_WEEKDAY) |=> (regRdData == $past(q.weekday));
   endproperty
   a_readLatency: assert property (p_readLatency)
      else $error("weekday read data wrong one cycle after the strobe");

   property p_formatSelect;
      regWr && (regAddr == `OFS_CONFIG)
         |=> (binaryFormatSelect == $past(regWrData[`CFG_BINARY_POS]));
   endproperty
   a_formatSelect: assert property (p_formatSelect)
      else $error("format selection did not follow the write");

   property p_setWins;
      alarmHit |=> q.status[`IRQ_ALARM_POS];
   endproperty
   a_setWins: assert property (p_setWins)
      else $error("alarm status lost against a clear");

   property p_dayStatus;
      dayRollover |=> q.status[`IRQ_DAY_POS];
   endproperty
   a_dayStatus: assert property (p_dayStatus)
      else $error("day rollover did not set its status bit");

   property p_weekdayRange;
      dayRollover && !regWr
         |=> (q.weekday >= `WEEKDAY_FIRST) && (q.weekday <= `WEEKDAY_LAST);
   endproperty
   a_weekdayRange: assert property (p_weekdayRange)
      else $error("weekday left the range 1 to 7 after a rollover");

   property p_weekdayStep;
      dayRollover && !regWr && (q.weekday >= `WEEKDAY_FIRST) && (q.weekday < `WEEKDAY_LAST)
         |=> (q.weekday == $past(q.weekday) + 8'h01);
   endproperty
   a_weekdayStep: assert property (p_weekdayStep)
      else $error("weekday did not step by one");

   property p_dateRange;
      dayRollover && !regWr && binaryFormatSelect
         |=> (q.date >= 8'h01) && (q.date <= 8'h1f);
   endproperty
   a_dateRange: assert property (p_dateRange)
      else $error("date left the range 1 to 31 after a rollover");

   property p_monthRange;
      dayRollover && !regWr && binaryFormatSelect && (q.month >= 8'h01) && (q.month <= 8'h0c)
         |=> (q.month >= 8'h01) && (q.month <= 8'h0c);
   endproperty
   a_monthRange: assert property (p_monthRange)
      else $error("month left the range 1 to 12 after a rollover");

   property p_yearRange;
      dayRollover && !regWr && binaryFormatSelect && (q.year <= 8'h63)
         |=> (q.year <= 8'h63);
   endproperty
   a_yearRange: assert property (p_yearRange)
      else $error("year left the range 0 to 99 after a rollover");

   property p_bcdYear;
      dayRollover && !regWr && !binaryFormatSelect && (q.month == 8'h12)
         && (q.date == 8'h31) && (q.year == 8'h99)
         |=> (q.year == 8'h00) && (q.month == 8'h01) && (q.date == 8'h01);
   endproperty
   a_bcdYear: assert property (p_bcdYear)
      else $error("BCD year did not wrap from 99 to 0");

   property p_hourFormat;
      regWr && (regAddr == `OFS_CONFIG)
         |=> (hour24Select == $past(regWrData[`CFG_HOUR24_POS]));
   endproperty
   a_hourFormat: assert property (p_hourFormat)
      else $error("hour format selection did not follow the write");

   property p_readIdle;
      !regRd |=> (regRdData == 8'h00);
   endproperty
   a_readIdle: assert property (p_readIdle)
      else $error("read data not zero outside the read cycle");

   property p_bcdLeap;
      dayRollover && !regWr && !binaryFormatSelect && (q.month == 8'h02)
         && (q.date == 8'h28) && (q.year == 8'h24)
         |=> (q.date == 8'h29) && (q.month == 8'h02);
   endproperty
   a_bcdLeap: assert property (p_bcdLeap)
      else $error("BCD leap year February ended on the 28th");
endmodule

// *** bench/tb_rtc_calendar.sv ***
// Self-checking testbench for the calendar counters and hour alarm block
`timescale 1ns/1ps
`include "rtc_cal_regs.svh"
module tb_rtc_calendar
   import rtc_cal_pkg::*;
;
   logic     ref_clk;
   logic     rstn;
   byte_type regAddr;
   byte_type regWrData;
   logic     regWr;
   logic     regRd;
   byte_type regRdData;
   logic     updateTick;
   logic     dayRollover;
   byte_type secondsCount;
   byte_type minutesCount;
   byte_type hoursCount;
   byte_type secondsAlarm;
   byte_type minutesAlarm;
   logic     binaryFormatSelect;
   logic     hour24Select;
   logic     alarmEvent;
   logic     irq;
   int       fail_count;
   int       checked;

   rtc_calendar dut (
      .ref_clk            (ref_clk),
      .rstn               (rstn),
      .regAddr            (regAddr),
      .regWrData          (regWrData),
      .regWr              (regWr),
      .regRd              (regRd),
      .regRdData          (regRdData),
      .updateTick         (updateTick),
      .dayRollover        (dayRollover),
      .secondsCount       (secondsCount),
      .minutesCount       (minutesCount),
      .hoursCount         (hoursCount),
      .secondsAlarm       (secondsAlarm),
      .minutesAlarm       (minutesAlarm),
      .binaryFormatSelect (binaryFormatSelect),
      .hour24Select       (hour24Select),
      .alarmEvent         (alarmEvent),
      .irq                (irq)
   );

   // ----------------------------------------
   // Compare and bus tasks
   // ----------------------------------------
   task automatic chk(input byte_type got, input byte_type exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkBit(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
      end
   endtask

   task automatic wr(input byte_type a, input byte_type d);
      @(posedge ref_clk);
      regWr     <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe, so sample it there
   task automatic rdChk(input byte_type a, input byte_type e);
      @(posedge ref_clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1;
      chk(regRdData, e);
   endtask

   task automatic tickChk(input byte_type sa, input byte_type ma, input byte_type s,
                          input byte_type m, input byte_type h, input logic e);
      @(posedge ref_clk);
      secondsAlarm <= sa;
      minutesAlarm <= ma;
      secondsCount <= s;
      minutesCount <= m;
      hoursCount   <= h;
      updateTick   <= 1'b1;
      @(posedge ref_clk);
      updateTick <= 1'b0;
      #1;
      chkBit(alarmEvent, e);
      @(posedge ref_clk);
      #1;
      chkBit(alarmEvent, 1'b0);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_reset();
      byte_type ofs [8];
      ofs = '{`OFS_HOUR_ALARM, `OFS_WEEKDAY, `OFS_DATE, `OFS_MONTH, `OFS_YEAR,
              `OFS_CONFIG, `OFS_IRQ_STATUS, `OFS_IRQ_MASK};
      foreach (ofs[i])
         rdChk(ofs[i], `RST_COUNTER);
      chkBit(binaryFormatSelect, 1'b0);
      chkBit(hour24Select, 1'b0);
      chkBit(irq, 1'b0);
      wr(8'h0a, 8'h55);
      rdChk(8'h0a, 8'h00);
   endtask

   // Fields packed weekday, date, month, year from the top byte down
   task automatic roll(input byte_type cfg, input logic [31:0] v, input logic [31:0] e);
      wr(`OFS_CONFIG, cfg);
      for (int i = 0; i < 4; i++)
         wr(byte_type'(`OFS_WEEKDAY + i), v[8*(3-i) +: 8]);
      rdChk(`OFS_CONFIG, cfg);
      chkBit(binaryFormatSelect, cfg[`CFG_BINARY_POS]);
      for (int i = 0; i < 4; i++)
         rdChk(byte_type'(`OFS_WEEKDAY + i), v[8*(3-i) +: 8]);
      @(posedge ref_clk);
      dayRollover <= 1'b1;
      @(posedge ref_clk);
      dayRollover <= 1'b0;
      for (int i = 0; i < 4; i++)
         rdChk(byte_type'(`OFS_WEEKDAY + i), e[8*(3-i) +: 8]);
      @(posedge ref_clk);
      #1;
      chk(regRdData, 8'h00);
      rdChk(`OFS_IRQ_STATUS, 8'h02);
      wr(`OFS_IRQ_STATUS, 8'h02);
      rdChk(`OFS_IRQ_STATUS, 8'h00);
   endtask

   task automatic test_rollover();
      roll(8'h04, 32'h071f0c63, 32'h01010100);
      roll(8'h04, 32'h031c0204, 32'h041d0204);
      roll(8'h04, 32'h031c0205, 32'h04010305);
      roll(8'h00, 32'h06311299, 32'h07010100);
      roll(8'h00, 32'h01090519, 32'h02100519);
      roll(8'h00, 32'h02300420, 32'h03010520);
      roll(8'h06, 32'h051e0b10, 32'h06010c10);
      roll(8'h00, 32'h00280224, 32'h01290224);
   endtask

   task automatic test_alarm();
      wr(`OFS_CONFIG, 8'h00);
      wr(`OFS_IRQ_MASK, 8'h01);
      wr(`OFS_HOUR_ALARM, 8'h85);
      rdChk(`OFS_HOUR_ALARM, 8'h85);
      tickChk(8'h12, 8'h34, 8'h12, 8'h34, 8'h05, 1'b0);
      chkBit(irq, 1'b0);
      tickChk(8'h12, 8'h34, 8'h12, 8'h34, 8'h85, 1'b1);
      chkBit(irq, 1'b1);
      rdChk(`OFS_IRQ_STATUS, 8'h01);
      wr(`OFS_IRQ_STATUS, 8'h01);
      #1;
      chkBit(irq, 1'b0);
      tickChk(8'h12, 8'h34, 8'h12, 8'h35, 8'h85, 1'b0);
      tickChk(8'h12, 8'hc0, 8'h12, 8'h35, 8'h85, 1'b1);
      tickChk(8'h12, 8'hc0, 8'h13, 8'h35, 8'h85, 1'b0);
      wr(`OFS_HOUR_ALARM, 8'hc3);
      tickChk(8'hff, 8'hc0, 8'h13, 8'h35, 8'h11, 1'b1);
      wr(`OFS_IRQ_MASK, 8'h00);
      #1;
      chkBit(irq, 1'b0);
      rdChk(`OFS_IRQ_STATUS, 8'h01);
      wr(`OFS_IRQ_STATUS, 8'h01);
   endtask

   // Hour alarm writes in 24-hour mode drop the afternoon flag unless wildcard
   task automatic test_hour24();
      wr(`OFS_CONFIG, 8'h02);
      #1;
      chkBit(hour24Select, 1'b1);
      wr(`OFS_HOUR_ALARM, 8'h93);
      rdChk(`OFS_HOUR_ALARM, 8'h13);
      tickChk(8'hc0, 8'hc0, 8'h00, 8'h00, 8'h93, 1'b1);
      tickChk(8'hc0, 8'hc0, 8'h00, 8'h00, 8'h14, 1'b0);
      wr(`OFS_HOUR_ALARM, 8'hd5);
      rdChk(`OFS_HOUR_ALARM, 8'hd5);
   endtask

   // A reset in mid-run must clear format, counters, status and mask alike
   task automatic test_midreset();
      wr(`OFS_CONFIG, 8'h06);
      wr(`OFS_DATE, 8'h15);
      wr(`OFS_IRQ_MASK, 8'h02);
      @(posedge ref_clk);
      dayRollover <= 1'b1;
      @(posedge ref_clk);
      dayRollover <= 1'b0;
      #1;
      chkBit(irq, 1'b1);
      @(posedge ref_clk);
      rstn <= 1'b0;
      #1;
      chkBit(irq, 1'b0);
      chkBit(binaryFormatSelect, 1'b0);
      chkBit(hour24Select, 1'b0);
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      rdChk(`OFS_DATE, `RST_COUNTER);
      rdChk(`OFS_CONFIG, 8'h00);
      rdChk(`OFS_IRQ_STATUS, 8'h00);
      rdChk(`OFS_IRQ_MASK, 8'h00);
   endtask

   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      ref_clk = 1'b0;
      forever
         #12.5 ref_clk = ~ref_clk;
   end

   initial
   begin
      #(25 * 20000);
      fail_count++;
      report_and_stop();
   end

   initial
   begin
      fail_count   = 0;
      checked      = 0;
      rstn         = 1'b0;
      regAddr      = 8'h00;
      regWrData    = 8'h00;
      regWr        = 1'b0;
      regRd        = 1'b0;
      updateTick   = 1'b0;
      dayRollover  = 1'b0;
      secondsCount = 8'h00;
      minutesCount = 8'h00;
      hoursCount   = 8'h00;
      secondsAlarm = 8'h00;
      minutesAlarm = 8'h00;
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      test_reset();
      test_rollover();
      test_alarm();
      test_hour24();
      test_midreset();
      report_and_stop();
   end
endmodule
